/* File: common/trace_pkg.sv */
// Constants and carrier types for the control-flow trace buffer
package trace_pkg;
    localparam int          ENTRIES     = 256;
    localparam logic [8:0]  FILL_MAX    = 9'h100;
    localparam logic [8:0]  FILL_LAST   = 9'h0FF;
    localparam logic [3:0]  REG_TRACE   = 4'hB;
    localparam logic [3:0]  REG_CHK0    = 4'hC;
    localparam logic [3:0]  REG_CHK1    = 4'hD;
    localparam logic [3:0]  CNT_MAX     = 4'hF;
    localparam logic [7:0]  MSG_ROLL    = 8'hFF;
    localparam logic [3:0]  MSG_DIRECT  = 4'h8;
    localparam logic [3:0]  MSG_INDIR   = 4'h9;
    localparam int          CHK_BIT     = 6;
    localparam logic [2:0]  ADDR_BYTES  = 3'h4;
    localparam logic [2:0]  NEED_INDIR  = 3'h5;
    localparam logic [2:0]  NEED_ONE    = 3'h1;
    localparam logic [2:0]  NEED_NONE   = 3'h0;

    typedef enum logic [2:0] {
        KIND_NONBR  = 3'h0,
        KIND_DIRECT = 3'h1,
        KIND_INDIR  = 3'h2,
        KIND_EXC    = 3'h3,
        KIND_DBGEXC = 3'h4
    } evt_kind_t;

    typedef struct packed {
        evt_kind_t   kind;
        logic        chkpt;
        logic [2:0]  vec;
        logic [31:0] target;
    } evt_t;

    typedef struct packed {
        logic        valid;
        logic        data_op;
        logic        write;
        logic        user_mode;
        logic [3:0]  crn;
        logic [31:0] wdata;
    } cp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ADDR = 3'b010,
        ST_FULL = 3'b100
    } wr_state_t;
endpackage : trace_pkg

/* File: verilog/trace_fifo.sv */
// Small valid/ready FIFO between the pipeline and the trace writer
`timescale 1ns/1ps
`default_nettype none
module trace_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wp_q;
    logic [AW:0]      rp_q;
    wire              push  = in_valid_i & in_ready_o;
    wire              pop   = out_valid_o & out_ready_i;
    wire  [AW:0]      level = wp_q - rp_q;

    assign in_ready_o  = level != (AW+1)'(DEPTH);
    assign out_valid_o = level != '0;
    assign out_data_o  = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + (AW+1)'(1);
            if (pop) rp_q <= rp_q + (AW+1)'(1);
        end
    end

    // Storage is not reset; only the pointers define validity
    always_ff @(posedge mclk_i) begin
        if (push) mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
endmodule : trace_fifo
`default_nettype wire

/* File: verilog/trace_buffer.sv */
// Control-flow trace buffer with checkpoint registers
`timescale 1ns/1ps
`default_nettype none
module trace_buffer #(
    parameter int unsigned FIFO_DEPTH = 4
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             trace_en_i,
    input  wire logic             wrap_mode_i,
    input  wire trace_pkg::evt_t  evt_i,
    input  wire logic             evt_valid_i,
    output logic                  evt_ready_o,
    input  wire trace_pkg::cp_req_t cp_req_i,
    output logic                  cp_ack_o,
    output logic                  cp_undef_o,
    output logic [31:0]           cp_rdata_o,
    output logic                  dbg_exc_o,
    output logic                  full_o
);
    localparam int EW = $bits(trace_pkg::evt_t);

    function automatic logic [7:0] make_msg(input trace_pkg::evt_t ev,
                                            input logic [3:0] cnt);
        logic [7:0] m;
        m = 8'h00;
        if (ev.kind == trace_pkg::KIND_EXC) begin
            m = {1'b0, ev.vec, cnt};
        end else if (ev.kind == trace_pkg::KIND_INDIR) begin
            m = {trace_pkg::MSG_INDIR, cnt};
        end else begin
            m = {trace_pkg::MSG_DIRECT, cnt};
        end
        if (ev.kind != trace_pkg::KIND_EXC && ev.chkpt) begin
            m[trace_pkg::CHK_BIT] = 1'b1;
        end
        return m;
    endfunction : make_msg

    logic                 en_q;
    logic                 exc_q;
    logic                 ack_q;
    logic                 undef_q;
    logic [31:0]          rdata_q;
    logic [3:0]           cnt_q;
    logic [3:0]           cnt_d;
    logic [3:0]           cnt_lat_q;
    logic [2:0]           idx_q;
    logic [7:0]           wr_ptr_q;
    logic [7:0]           rd_ptr_q;
    logic [8:0]           fill_q;
    logic [31:0]          chk0_q;
    logic [31:0]          chk1_q;
    logic [7:0]           mem_q [trace_pkg::ENTRIES];
    trace_pkg::evt_t      ev_q;
    trace_pkg::wr_state_t st_q;
    trace_pkg::wr_state_t st_d;

    logic                 f_in_ready;
    logic                 f_out_valid;
    logic [EW-1:0]        f_out_data;
    trace_pkg::evt_t      ev;
    logic                 pop;

    // Events offered while disabled are swallowed, not stalled
    assign evt_ready_o = f_in_ready | ~en_q;
    assign ev          = trace_pkg::evt_t'(f_out_data);

    trace_fifo #(
        .WIDTH (EW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (evt_valid_i & en_q),
        .in_ready_o  (f_in_ready),
        .in_data_i   (evt_i),
        .out_valid_o (f_out_valid),
        .out_ready_i (pop),
        .out_data_o  (f_out_data)
    );

    // Writer decode
    wire       idle    = st_q == trace_pkg::ST_IDLE;
    wire       in_addr = st_q == trace_pkg::ST_ADDR;
    assign pop         = f_out_valid & idle;
    wire       is_nb   = ev.kind == trace_pkg::KIND_NONBR;
    wire       is_dir  = ev.kind == trace_pkg::KIND_DIRECT;
    wire       is_ind  = ev.kind == trace_pkg::KIND_INDIR;
    wire       is_exc  = ev.kind == trace_pkg::KIND_EXC;
    wire       is_roll = is_nb & (cnt_q == trace_pkg::CNT_MAX);
    wire [2:0] need    = is_ind ? trace_pkg::NEED_INDIR :
                         (is_dir | is_exc | is_roll) ? trace_pkg::NEED_ONE :
                         trace_pkg::NEED_NONE;
    wire [8:0] room    = trace_pkg::FILL_MAX - fill_q;
    wire       no_fit  = pop & ~wrap_mode_i & ({6'h00, need} > room);
    wire       ok      = pop & ~no_fit;
    wire       wr_one  = ok & (need == trace_pkg::NEED_ONE);
    wire       wr_en   = wr_one | in_addr;
    wire       msg_now = in_addr & (idx_q == trace_pkg::ADDR_BYTES);
    wire       fill_last = wr_en & ~wrap_mode_i &
                           (fill_q == trace_pkg::FILL_LAST);
    wire       chk_upd = (wr_one & is_dir & ev.chkpt) |
                         (msg_now & ev_q.chkpt);
    wire [31:0] chk_tgt = in_addr ? ev_q.target : ev.target;
    wire [7:0] addr_byte = ev_q.target[8'(31 - 8*idx_q) -: 8];
    wire [7:0] wr_byte = in_addr ? (msg_now ? make_msg(ev_q, cnt_lat_q)
                                            : addr_byte)
                       : is_roll ? trace_pkg::MSG_ROLL
                       : make_msg(ev, cnt_q);

    assign cnt_d = ~pop ? cnt_q :
                   (ev.kind == trace_pkg::KIND_DBGEXC) ? cnt_q :
                   (is_nb & ~is_roll) ? cnt_q + 4'h1 : 4'h0;

    always_comb begin
        st_d = st_q;
        case (st_q)
            trace_pkg::ST_IDLE: begin
                if (no_fit) st_d = trace_pkg::ST_FULL;
                else if (ok && is_ind) st_d = trace_pkg::ST_ADDR;
                else if (fill_last) st_d = trace_pkg::ST_FULL;
            end
            trace_pkg::ST_ADDR: begin
                if (fill_last) st_d = trace_pkg::ST_FULL;
                else if (msg_now) st_d = trace_pkg::ST_IDLE;
            end
            trace_pkg::ST_FULL: begin
                if (!en_q) st_d = trace_pkg::ST_IDLE;
            end
            default: st_d = trace_pkg::ST_IDLE;
        endcase
    end

    // Coprocessor decode
    wire req     = cp_req_i.valid;
    wire bad     = cp_req_i.data_op | cp_req_i.user_mode;
    wire good    = req & ~bad;
    // Writes answer zero rather than stale register contents
    wire rd_ok   = good & ~cp_req_i.write;
    wire hit_tb  = cp_req_i.crn == trace_pkg::REG_TRACE;
    wire hit_c0  = cp_req_i.crn == trace_pkg::REG_CHK0;
    wire hit_c1  = cp_req_i.crn == trace_pkg::REG_CHK1;
    wire trace_rd = good & hit_tb & ~cp_req_i.write;
    wire sw_c0   = good & hit_c0 & cp_req_i.write & ~en_q;
    wire sw_c1   = good & hit_c1 & cp_req_i.write & ~en_q;
    wire [31:0] rd_mux = hit_tb ? {24'h000000, mem_q[rd_ptr_q]}
                       : hit_c0 ? chk0_q
                       : hit_c1 ? chk1_q : 32'h00000000;

    assign cp_ack_o   = ack_q;
    assign cp_undef_o = undef_q;
    assign cp_rdata_o = rdata_q;
    assign dbg_exc_o  = exc_q;
    assign full_o     = st_q == trace_pkg::ST_FULL;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            en_q  <= 1'b0;
            st_q  <= trace_pkg::ST_IDLE;
            exc_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            en_q  <= trace_en_i;
            st_q  <= st_d;
            exc_q <= no_fit | fill_last;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            idx_q     <= 3'h0;
            cnt_lat_q <= 4'h0;
            ev_q      <= '0;
        end else if (ok && is_ind) begin
            idx_q     <= 3'h0;
            cnt_lat_q <= cnt_q;
            ev_q      <= ev;
        end else if (in_addr) begin
            idx_q     <= idx_q + 3'h1;
        end
    end

    // Pointers are control state and restart at slot zero on reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            wr_ptr_q <= 8'h00;
            rd_ptr_q <= 8'h00;
            fill_q   <= 9'h000;
        end else begin
            if (wr_en) wr_ptr_q <= wr_ptr_q + 8'h01;
            if (wr_en) rd_ptr_q <= wr_ptr_q + 8'h01;
            else if (trace_rd) rd_ptr_q <= rd_ptr_q + 8'h01;
            if (trace_en_i && !en_q) fill_q <= 9'h000;
            else if (wr_en) fill_q <= fill_q + 9'h001;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack_q   <= 1'b0;
            undef_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= req;
            undef_q <= req & bad;
            rdata_q <= rd_ok ? rd_mux : 32'h00000000;
        end
    end

    // Checkpoints hold their value across reset; trace writes win
    always_ff @(posedge mclk_i) begin
        if (chk_upd) begin
            chk1_q <= chk0_q;
            chk0_q <= chk_tgt;
        end else begin
            if (sw_c0) chk0_q <= cp_req_i.wdata;
            if (sw_c1) chk1_q <= cp_req_i.wdata;
        end
    end

    // Contents survive reset; writer has priority over clear
    always_ff @(posedge mclk_i) begin
        if (wr_en) mem_q[wr_ptr_q] <= wr_byte;
        else if (trace_rd) mem_q[rd_ptr_q] <= 8'h00;
    end

    undef_dataop_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        req && cp_req_i.data_op |=> cp_ack_o && cp_undef_o)
        else $error("data op did not trap");
    undef_user_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        req && cp_req_i.user_mode |=> cp_undef_o)
        else $error("user access did not trap");
    read_clear_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        trace_rd && !wr_en |=> mem_q[$past(rd_ptr_q)] == 8'h00 &&
        cp_rdata_o[31:8] == 24'h000000)
        else $error("read byte not cleared");
    read_step_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        trace_rd && !wr_en |=> rd_ptr_q == $past(rd_ptr_q) + 8'h01)
        else $error("read pointer did not advance");
    full_stop_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        full_o |-> (!wr_en && !wrap_mode_i) || !en_q)
        else $error("write while full");
    wrap_nofull_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        wrap_mode_i && !full_o && $stable(wrap_mode_i) |=> !full_o)
        else $error("wrap mode went full");
    chk_shift_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        chk_upd |=> chk1_q == $past(chk0_q) &&
        chk0_q == $past(chk_tgt))
        else $error("checkpoint shift wrong");
    chk_bit_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        chk_upd |-> wr_en && wr_byte[trace_pkg::CHK_BIT])
        else $error("checkpoint bit missing");
    rollover_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ok && is_roll |-> wr_en && wr_byte == 8'hFF ##1 cnt_q == 4'h0)
        else $error("rollover byte wrong");
    indir_len_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ok && is_ind |=> (in_addr && wr_en)[*5] ##1 !in_addr)
        else $error("indirect entry not five bytes");
    dbg_skip_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        pop && ev.kind == trace_pkg::KIND_DBGEXC |-> !wr_en)
        else $error("debug exception recorded");
    reset_off_a: assert property (
        @(posedge mclk_i)
        rst_i |=> !en_q && !full_o)
        else $error("reset left tracing on");
    write_zero_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        req && cp_req_i.write |=> cp_ack_o && cp_rdata_o == 32'h00000000)
        else $error("write returned read data");

    cov_indirect_c: cover property (@(posedge mclk_i) msg_now);
    cov_full_c:     cover property (@(posedge mclk_i) $rose(full_o));
    cov_wrap_c:     cover property (@(posedge mclk_i)
        wrap_mode_i && wr_en && wr_ptr_q == 8'hFF);
    cov_read_c:     cover property (@(posedge mclk_i) trace_rd);
    cov_roll_c:     cover property (@(posedge mclk_i) ok && is_roll);
endmodule : trace_buffer
`default_nettype wire

/* File: verif/evt_source.sv */
// Pipeline-side event source model feeding the trace buffer
`timescale 1ns/1ps
`default_nettype none
module evt_source (
    input  wire logic       mclk_i,
    input  wire logic       stall_i,
    input  wire logic       evt_ready_i,
    output var trace_pkg::evt_t evt_o,
    output logic            evt_valid_o
);
    trace_pkg::evt_t q[$];
    initial begin
        evt_valid_o = 1'b0;
        evt_o       = '0;
    end
    task automatic push(input trace_pkg::evt_t e);
        q.push_back(e);
    endtask : push
    // Offer held until taken; idle data inverted so stale values never match
    always @(posedge mclk_i) begin
        if (evt_valid_o && evt_ready_i) begin
            void'(q.pop_front());
        end
        if (!evt_valid_o || evt_ready_i) begin
            if (q.size() != 0 && !stall_i) begin
                evt_o       <= q[0];
                evt_valid_o <= 1'b1;
            end else begin
                evt_o       <= trace_pkg::evt_t'(~evt_o);
                evt_valid_o <= 1'b0;
            end
        end
    end
endmodule : evt_source
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the control-flow trace buffer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LIMIT = 40000;
    logic               mclk_i;
    logic               rst_i;
    logic               trace_en_i;
    logic               wrap_mode_i;
    logic               stall;
    trace_pkg::evt_t    evt;
    logic               evt_valid;
    logic               evt_ready;
    trace_pkg::cp_req_t cp_req;
    logic               cp_ack;
    logic               cp_undef;
    logic [31:0]        cp_rdata;
    logic               dbg_exc;
    logic               full;
    logic [33:0]        exp_q[$];
    logic [7:0]         exp_buf[256];
    logic [33:0]        e;
    logic [31:0]        ta;
    logic [31:0]        tb;
    int                 mismatches;
    int                 total_checks;
    int                 exc_seen;
    int                 cycles;
    integer             seed;

    trace_buffer #(.FIFO_DEPTH(4)) dut_u (
        .mclk_i(mclk_i), .rst_i(rst_i), .trace_en_i(trace_en_i),
        .wrap_mode_i(wrap_mode_i), .evt_i(evt), .evt_valid_i(evt_valid),
        .evt_ready_o(evt_ready), .cp_req_i(cp_req), .cp_ack_o(cp_ack),
        .cp_undef_o(cp_undef), .cp_rdata_o(cp_rdata), .dbg_exc_o(dbg_exc),
        .full_o(full));
    evt_source src_u (.mclk_i(mclk_i), .stall_i(stall),
        .evt_ready_i(evt_ready), .evt_o(evt), .evt_valid_o(evt_valid));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [32:0] exp,
                         input logic [32:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Expectation layout: {compare, undef, read data}
    task automatic cp(input logic wr, input logic dop, input logic usr,
                      input logic [3:0] crn, input logic [31:0] wd,
                      input logic [33:0] exp);
        @(posedge mclk_i);
        cp_req <= '{1'b1, dop, wr, usr, crn, wd};
        exp_q.push_back(exp);
    endtask : cp

    task automatic cp_idle();
        @(posedge mclk_i);
        cp_req.valid <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask : cp_idle

    // Back-to-back reads, one per cycle, with junk on the write data
    task automatic readout(input logic chk);
        for (int i = 0; i < 256; i++) begin
            cp(1'b0, 1'b0, 1'b0, trace_pkg::REG_TRACE, $random(seed),
               {chk, 1'b0, 24'h0, exp_buf[i]});
        end
        cp_idle();
    endtask : readout

    task automatic ev(input trace_pkg::evt_kind_t k, input logic c,
                      input logic [2:0] v, input logic [31:0] t);
        src_u.push('{k, c, v, t});
    endtask : ev

    // No completion flag on the event side: drain source, then let writer end
    task automatic settle();
        @(posedge mclk_i);
        while (src_u.q.size() != 0 || evt_valid) @(posedge mclk_i);
        repeat (40) @(posedge mclk_i);
    endtask : settle

    task automatic trace_on(input logic wrap);
        wrap_mode_i <= wrap;
        trace_en_i  <= 1'b1;
        repeat (2) @(posedge mclk_i);
    endtask : trace_on

    always @(posedge mclk_i) begin
        cycles++;
        stall <= (($random(seed) & 3) == 0);
        if (dbg_exc === 1'b1) exc_seen++;
        if (cp_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected ack", 33'h0, {1'b1, cp_rdata});
            end else begin
                e = exp_q.pop_front();
                if (e[33]) check("cp result", e[32:0], {cp_undef, cp_rdata});
            end
        end
        if (cycles == LIMIT) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        seed = 32'hEBD3;
        mismatches = 0;
        total_checks = 0;
        exc_seen = 0;
        cycles = 0;
        rst_i = 1'b1;
        trace_en_i = 1'b0;
        wrap_mode_i = 1'b0;
        cp_req = '0;
        stall = 1'b0;
        ta = $random(seed);
        tb = $random(seed);
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        // Power-up bytes unknown: first pass only clears them
        readout(1'b0);
        for (int i = 0; i < 256; i++) exp_buf[i] = 8'h00;
        cp(1'b0, 1'b1, 1'b0, trace_pkg::REG_CHK0, '0, 34'h3_0000_0000);
        cp(1'b0, 1'b0, 1'b1, trace_pkg::REG_TRACE, '0, 34'h3_0000_0000);
        cp(1'b1, 1'b0, 1'b0, trace_pkg::REG_CHK0, ta, {2'b10, 32'h0});
        cp(1'b1, 1'b0, 1'b0, trace_pkg::REG_CHK1, tb, {2'b10, 32'h0});
        cp(1'b0, 1'b0, 1'b0, trace_pkg::REG_CHK0, '0, {2'b10, ta});
        cp(1'b0, 1'b0, 1'b0, trace_pkg::REG_CHK1, '0, {2'b10, tb});
        cp(1'b0, 1'b0, 1'b0, 4'hE, '0, {2'b10, 32'h0});
        cp_idle();
        readout(1'b1);
        $display("test registers and clear done");

        ta = $random(seed);
        tb = $random(seed);
        trace_on(1'b0);
        for (int i = 0; i < 3; i++) ev(trace_pkg::KIND_NONBR, 1'b0, 3'h0, 32'h0);
        ev(trace_pkg::KIND_DIRECT, 1'b1, 3'h0, ta);
        ev(trace_pkg::KIND_INDIR, 1'b1, 3'h0, tb);
        ev(trace_pkg::KIND_DBGEXC, 1'b0, 3'h7, 32'h0);
        ev(trace_pkg::KIND_EXC, 1'b0, 3'h5, 32'h0);
        for (int i = 0; i < 16; i++) ev(trace_pkg::KIND_NONBR, 1'b0, 3'h0, 32'h0);
        settle();
        trace_en_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        exp_buf[248] = 8'hC3;
        {exp_buf[249], exp_buf[250], exp_buf[251], exp_buf[252]} = tb;
        exp_buf[253] = 8'hD0;
        exp_buf[254] = 8'h50;
        exp_buf[255] = 8'hFF;
        readout(1'b1);
        cp(1'b0, 1'b0, 1'b0, trace_pkg::REG_CHK0, '0, {2'b10, tb});
        cp(1'b0, 1'b0, 1'b0, trace_pkg::REG_CHK1, '0, {2'b10, ta});
        cp_idle();
        $display("test capture done");

        trace_on(1'b0);
        for (int i = 0; i < 256; i++) ev(trace_pkg::KIND_EXC, 1'b0, 3'h2, 32'h0);
        settle();
        check("full flag", 33'h1, {32'h0, full});
        check("debug exceptions", 33'h1, 33'(exc_seen));
        trace_en_i <= 1'b0;
        rst_i      <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        check("full after reset", 33'h0, {32'h0, full});
        for (int i = 0; i < 256; i++) exp_buf[i] = 8'h20;
        readout(1'b1);
        $display("test fill-once done");

        // Oldest exception bytes must be overwritten by later branches
        trace_on(1'b1);
        for (int i = 0; i < 4; i++) ev(trace_pkg::KIND_EXC, 1'b0, 3'h1, 32'h0);
        for (int i = 0; i < 256; i++) begin
            ev(trace_pkg::KIND_DIRECT, 1'b0, 3'h0, $random(seed));
        end
        settle();
        trace_en_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        for (int i = 0; i < 256; i++) exp_buf[i] = 8'h80;
        readout(1'b1);
        check("debug exceptions", 33'h1, 33'(exc_seen));
        $display("test wrap-around done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
